// File: astx_pkg.sv
// Shared constants and types for the serial transceiver
package astx_pkg;
	// Read addresses (address bits 2..0)
	localparam logic [2:0] RD_CONTROL_ONE = 3'h0;
	localparam logic [2:0] RD_CONTROL_TWO = 3'h2;
	localparam logic [2:0] RD_LINE_STATUS = 3'h4;
	localparam logic [2:0] RD_RECEIVE_HOLDING = 3'h6;
	// Write addresses (address bits 2..0)
	localparam logic [2:0] WR_CONTROL_ONE = 3'h0;
	localparam logic [2:0] WR_CONTROL_TWO = 3'h2;
	localparam logic [2:0] WR_SYNC_ESCAPE = 3'h4;
	localparam logic [2:0] WR_TRANSMIT_HOLDING = 3'h6;
	// Control one fields
	localparam int C1_RX_ENABLE = 0;
	localparam int C1_TX_REQUEST = 1;
	localparam int C1_LOOPBACK = 2;
	localparam int C1_SYNC_MODE = 3;
	localparam int C1_ESC_STRIP = 4;
	localparam int C1_FORCE_ESC = 5;
	localparam int C1_TRANSPARENT = 6;
	// Control two fields
	localparam int C2_LEN_LSB = 0;
	localparam int C2_HALF_STOP = 2;
	localparam int C2_SYN_STRIP = 3;
	localparam int C2_TWO_STOP = 4;
	localparam int C2_CLK_SEL_LSB = 5;
	// Line status fields
	localparam int ST_DATA_RECEIVED = 0;
	localparam int ST_OVERRUN = 1;
	localparam int ST_FRAMING = 2;
	localparam int ST_STRIPPED = 3;
	localparam int ST_TX_EMPTY = 4;
	localparam int ST_SYNC_LOCK = 5;
	localparam int ST_CLEAR_TO_SEND = 6;
	// Reset values and timing counts
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [3:0] MIN_CHAR_BITS = 4'h5;
	localparam logic [3:0] MAX_CHAR_BITS = 4'h8;
	localparam logic [4:0] OVERSAMPLE_LAST = 5'h1F;
	localparam logic [4:0] OVERSAMPLE_HALF = 5'h0F;
	localparam logic [2:0] CLK_SEL_1X = 3'h0;
	localparam int RATE_CLOCKS = 4;
	localparam int RX_FIFO_DEPTH = 8;
	typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_STOP} astx_rx_state_t;
	typedef enum logic [1:0] {SY_HUNT, SY_FIRST, SY_LOCK} astx_sync_state_t;
	typedef enum logic [1:0] {
		TX_IDLE, TX_START, TX_DATA, TX_STOP
	} astx_tx_state_t;
endpackage

// File: astx_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module astx_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign in_ready = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data = mem_reg[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 :
					AW'(wr_ptr_reg + 1'b1);
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 :
					AW'(rd_ptr_reg + 1'b1);
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule

// File: astx_transceiver.sv
// Async/sync serial transceiver behind a multiplexed parallel bus
`timescale 1ns/1ps
// Notes on behaviour
// - Received character goes right-aligned to holding, upper bits zero.
// - Sync character register is write-only; reads never show it.
// - Sync mode strips matching sync/escape characters and flags the strip.
// - Transparent transmit can force one escape before a data character.
// - Both control registers read and write; reset clears them.
// - Holding moves to shifter only when enabled and shifter ready.
// - Shifter loads from transmit holding, sync or escape register.
// - Async frame: start bit at 0, stop bits at 1.
// - Async receive starts on start bit only after a stop period.
// - Async receiver keeps only data bits.
// - Zero stop bit sets framing error and becomes next start bit.
// - After framing error, continue only if centre still samples 0.
// - Break gives zero characters with errors; first 1 restores ready.
// - Async transmit: start, data bits, 1, 1.5 (32X clocks only, 2 on 1X) or 2 stop bits.
// - Waiting character follows stop at once, else line stays mark.
// - Sync hunt: look for sync pair, no holding load or status.
// - Two sync matches lock until receive enable cleared.
// - Sync transmit never idles: fills with sync or escape-sync.
// - Character length is five to eight bits in both modes.
// - One 1X clock or one of four 32X clocks selects rate.
// - Diagnostic loop feeds transmit output into the receiver.
// - Transparent select bit at 1 makes sync transmit transparent.
module astx_transceiver #(
	parameter int FIFO_DEPTH = astx_pkg::RX_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// Parallel access bus
	input wire logic [7:0] PARALLEL_ACCESS_BUS_IN,
	output logic [7:0] PARALLEL_ACCESS_BUS_OUT,
	output logic PARALLEL_ACCESS_BUS_OE,
	input wire logic CHIP_SELECT_N,
	input wire logic READ_ENABLE_N,
	input wire logic WRITE_ENABLE_N,
	input wire logic [4:0] DEVICE_ID,
	output logic REPLY_N,
	// Serial line and modem control
	input wire logic RX_DATA,
	output logic TX_DATA,
	input wire logic CLEAR_TO_SEND_N,
	output logic REQUEST_TO_SEND_N,
	// Rate clocks
	input wire logic LINE_CLK_1X,
	input wire logic [3:0] RATE_CLK_32X
);
	localparam int NSYNC = 23;

	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] sync_1_reg;
	logic [NSYNC-1:0] sync_2_reg;
	logic [NSYNC-1:8] prev_reg;
	logic [7:0] dal_s;
	logic cs_n_s, re_n_s, we_n_s, rxd_s, cts_n_s, clk1x_s;
	logic [4:0] id_s;
	logic [3:0] rate_s;

	// All pins except CLK and RESETN pass two flops before use
	assign async_in = {RATE_CLK_32X, LINE_CLK_1X, CLEAR_TO_SEND_N, RX_DATA,
		DEVICE_ID, WRITE_ENABLE_N, READ_ENABLE_N, CHIP_SELECT_N,
		PARALLEL_ACCESS_BUS_IN};

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			sync_1_reg <= {NSYNC{1'b1}};
			sync_2_reg <= {NSYNC{1'b1}};
			prev_reg <= {(NSYNC-8){1'b1}};
		end else begin
			sync_1_reg <= async_in;
			sync_2_reg <= sync_1_reg;
			prev_reg <= sync_2_reg[NSYNC-1:8];
		end
	end

	assign dal_s = sync_2_reg[7:0];
	assign cs_n_s = sync_2_reg[8];
	assign re_n_s = sync_2_reg[9];
	assign we_n_s = sync_2_reg[10];
	assign id_s = sync_2_reg[15:11];
	assign rxd_s = sync_2_reg[16];
	assign cts_n_s = sync_2_reg[17];
	assign clk1x_s = sync_2_reg[18];
	assign rate_s = sync_2_reg[22:19];

	// Registers
	logic [7:0] control_one_reg, control_two_reg;
	logic [7:0] sync_character_reg, escape_character_reg;
	logic [7:0] transmit_holding_reg, receive_holding_reg;
	logic hold_full_reg, dr_reg, overrun_reg, framing_reg, stripped_reg;
	logic esc_next_reg;
	logic [2:0] addr_reg;
	logic selected_reg;
	logic sync_locked;

	// Mode decode
	logic [3:0] char_bits;
	logic [2:0] clk_sel;
	logic use_1x, tick32, x1_rise, x1_fall, sync_mode, rx_en, tx_en;
	logic [1:0] rate_idx;

	assign char_bits = astx_pkg::MIN_CHAR_BITS +
		{2'b00, control_two_reg[astx_pkg::C2_LEN_LSB +: 2]};
	assign clk_sel = control_two_reg[astx_pkg::C2_CLK_SEL_LSB +: 3];
	assign use_1x = (clk_sel == astx_pkg::CLK_SEL_1X) ||
		(clk_sel > 3'(astx_pkg::RATE_CLOCKS));
	assign rate_idx = 2'(clk_sel - 3'h1);
	assign tick32 = rate_s[rate_idx] && !prev_reg[19 + rate_idx];
	assign x1_rise = clk1x_s && !prev_reg[18];
	assign x1_fall = !clk1x_s && prev_reg[18];
	assign sync_mode = control_one_reg[astx_pkg::C1_SYNC_MODE];
	assign rx_en = control_one_reg[astx_pkg::C1_RX_ENABLE];
	assign tx_en = control_one_reg[astx_pkg::C1_TX_REQUEST] &&
		!cts_n_s;

	// Parallel bus access
	logic cs_fall, rd_end, wr_stb, hit;
	logic [7:0] rd_mux;
	assign cs_fall = !cs_n_s && prev_reg[8];
	assign hit = (dal_s[7:3] == id_s) && !dal_s[0];
	assign rd_end = selected_reg && re_n_s && !prev_reg[9];
	assign wr_stb = selected_reg && !we_n_s && prev_reg[10];

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			selected_reg <= 1'b0;
			addr_reg <= 3'h0;
		end else if (cs_fall) begin
			selected_reg <= hit;
			addr_reg <= dal_s[2:0];
		end else if (cs_n_s && re_n_s && we_n_s) begin
			selected_reg <= 1'b0;
		end
	end

	always_comb begin
		case (addr_reg)
		astx_pkg::RD_CONTROL_ONE: rd_mux = control_one_reg;
		astx_pkg::RD_CONTROL_TWO: rd_mux = control_two_reg;
		astx_pkg::RD_LINE_STATUS: begin
			rd_mux = 8'h00;
			rd_mux[astx_pkg::ST_DATA_RECEIVED] = dr_reg;
			rd_mux[astx_pkg::ST_OVERRUN] = overrun_reg;
			rd_mux[astx_pkg::ST_FRAMING] = framing_reg;
			rd_mux[astx_pkg::ST_STRIPPED] = stripped_reg;
			rd_mux[astx_pkg::ST_TX_EMPTY] = !hold_full_reg;
			rd_mux[astx_pkg::ST_SYNC_LOCK] = sync_locked;
			rd_mux[astx_pkg::ST_CLEAR_TO_SEND] = !cts_n_s;
		end
		astx_pkg::RD_RECEIVE_HOLDING: rd_mux = receive_holding_reg;
		default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			PARALLEL_ACCESS_BUS_OUT <= 8'h00;
			PARALLEL_ACCESS_BUS_OE <= 1'b0;
			REPLY_N <= 1'b1;
			REQUEST_TO_SEND_N <= 1'b1;
		end else begin
			PARALLEL_ACCESS_BUS_OUT <= rd_mux;
			PARALLEL_ACCESS_BUS_OE <= selected_reg && !re_n_s;
			REPLY_N <= !selected_reg;
			REQUEST_TO_SEND_N <= !control_one_reg[astx_pkg::C1_TX_REQUEST];
		end
	end

	// Register writes; sync and escape share one address in turn
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			control_one_reg <= astx_pkg::CONTROL_RESET;
			control_two_reg <= astx_pkg::CONTROL_RESET;
			sync_character_reg <= 8'h00;
			escape_character_reg <= 8'h00;
			transmit_holding_reg <= 8'h00;
			esc_next_reg <= 1'b0;
		end else if (wr_stb) begin
			esc_next_reg <= 1'b0;
			case (addr_reg)
			astx_pkg::WR_CONTROL_ONE: control_one_reg <= dal_s;
			astx_pkg::WR_CONTROL_TWO: control_two_reg <= dal_s;
			astx_pkg::WR_SYNC_ESCAPE: begin
				if (esc_next_reg) begin
					escape_character_reg <= dal_s;
				end else begin
					sync_character_reg <= dal_s;
					esc_next_reg <= 1'b1;
				end
			end
			astx_pkg::WR_TRANSMIT_HOLDING: transmit_holding_reg <= dal_s;
			default: esc_next_reg <= 1'b0;
			endcase
		end else if (rd_end || (cs_fall && !hit)) begin
			esc_next_reg <= 1'b0;
		end
	end

	// Transmitter
	astx_pkg::astx_tx_state_t tx_state_reg;
	logic [7:0] tx_shift_reg;
	logic [3:0] tx_count_reg;
	logic tx_stop_cnt_reg, tx_line_reg, esc_sent_reg, fill_phase_reg;
	logic [4:0] tx_div_reg, tx_div_end;
	logic tx_bit_end, can_load, do_load, stop_last, half_now, two_stops;
	logic sel_force, sel_hold, sel_fill_esc;
	logic [7:0] ld_data;

	assign two_stops = control_two_reg[astx_pkg::C2_TWO_STOP] ||
		control_two_reg[astx_pkg::C2_HALF_STOP];
	assign half_now = (tx_state_reg == astx_pkg::TX_STOP) && tx_stop_cnt_reg
		&& control_two_reg[astx_pkg::C2_HALF_STOP]
		&& !control_two_reg[astx_pkg::C2_TWO_STOP];
	assign tx_div_end = half_now ? astx_pkg::OVERSAMPLE_HALF :
		astx_pkg::OVERSAMPLE_LAST;
	assign tx_bit_end = use_1x ? x1_fall : (tick32 && tx_div_reg == tx_div_end);
	assign stop_last = (tx_stop_cnt_reg == two_stops);
	assign can_load = tx_en && (sync_mode || hold_full_reg);

	always_comb begin
		sel_force = hold_full_reg && !esc_sent_reg &&
			control_one_reg[astx_pkg::C1_FORCE_ESC] &&
			control_one_reg[astx_pkg::C1_TRANSPARENT];
		sel_hold = 1'b0;
		sel_fill_esc = 1'b0;
		if (sel_force) begin
			ld_data = escape_character_reg;
		end else if (hold_full_reg) begin
			ld_data = transmit_holding_reg;
			sel_hold = 1'b1;
		end else if (control_one_reg[astx_pkg::C1_TRANSPARENT] &&
				!fill_phase_reg) begin
			ld_data = escape_character_reg;
			sel_fill_esc = 1'b1;
		end else begin
			ld_data = sync_character_reg;
		end
		case (tx_state_reg)
		astx_pkg::TX_IDLE: do_load = tx_bit_end && can_load;
		astx_pkg::TX_DATA: do_load = tx_bit_end && can_load && sync_mode &&
			tx_count_reg == char_bits;
		astx_pkg::TX_STOP: do_load = tx_bit_end && can_load && stop_last;
		default: do_load = 1'b0;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			tx_div_reg <= 5'h00;
		end else if (tick32) begin
			tx_div_reg <= (tx_div_reg == tx_div_end) ? 5'h00 :
				5'(tx_div_reg + 1'b1);
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			tx_state_reg <= astx_pkg::TX_IDLE;
			tx_shift_reg <= 8'h00;
			tx_count_reg <= 4'h0;
			tx_stop_cnt_reg <= 1'b0;
			tx_line_reg <= 1'b1;
		end else if (do_load && !sync_mode) begin
			tx_shift_reg <= ld_data;
			tx_line_reg <= 1'b0;
			tx_state_reg <= astx_pkg::TX_START;
		end else if (do_load) begin
			tx_line_reg <= ld_data[0];
			tx_shift_reg <= {1'b0, ld_data[7:1]};
			tx_count_reg <= 4'h1;
			tx_state_reg <= astx_pkg::TX_DATA;
		end else if (tx_bit_end) begin
			case (tx_state_reg)
			astx_pkg::TX_START: begin
				tx_line_reg <= tx_shift_reg[0];
				tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
				tx_count_reg <= 4'h1;
				tx_state_reg <= astx_pkg::TX_DATA;
			end
			astx_pkg::TX_DATA: begin
				if (tx_count_reg == char_bits) begin
					tx_line_reg <= 1'b1;
					tx_stop_cnt_reg <= 1'b0;
					tx_state_reg <= sync_mode ? astx_pkg::TX_IDLE :
						astx_pkg::TX_STOP;
				end else begin
					tx_line_reg <= tx_shift_reg[0];
					tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
					tx_count_reg <= tx_count_reg + 1'b1;
				end
			end
			astx_pkg::TX_STOP: begin
				tx_stop_cnt_reg <= 1'b1;
				if (stop_last) begin
					tx_state_reg <= astx_pkg::TX_IDLE;
				end
			end
			default: tx_line_reg <= 1'b1;
			endcase
		end
	end

	// Holding full flag; a write wins over a same-cycle load
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			hold_full_reg <= 1'b0;
			esc_sent_reg <= 1'b0;
			fill_phase_reg <= 1'b0;
		end else begin
			if (wr_stb && addr_reg == astx_pkg::WR_TRANSMIT_HOLDING) begin
				hold_full_reg <= 1'b1;
			end else if (do_load && sel_hold) begin
				hold_full_reg <= 1'b0;
			end
			if (do_load) begin
				esc_sent_reg <= sel_force;
				fill_phase_reg <= sel_fill_esc;
			end
		end
	end

	// Line output follows clear-to-send at once
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			TX_DATA <= 1'b1;
		end else begin
			TX_DATA <= cts_n_s ? 1'b1 : tx_line_reg;
		end
	end

	// Receiver
	astx_pkg::astx_rx_state_t rx_state_reg;
	astx_pkg::astx_sync_state_t sync_state_reg;
	logic [7:0] rx_shift_reg, shifted, win, async_char, push_data_reg;
	logic [3:0] rx_count_reg;
	logic [4:0] rx_phase_reg;
	logic rx_line, rx_tick, mark_seen_reg, break_reg, win_match;
	logic push_reg, push_fe_reg, strip_evt_reg, strip_hit;

	assign rx_line = control_one_reg[astx_pkg::C1_LOOPBACK] ? tx_line_reg :
		rxd_s;
	assign rx_tick = use_1x ? x1_rise :
		(tick32 && rx_phase_reg == astx_pkg::OVERSAMPLE_HALF);
	assign shifted = {rx_line, rx_shift_reg[7:1]};
	assign win = 8'(shifted >> (astx_pkg::MAX_CHAR_BITS - char_bits));
	assign async_char = 8'(rx_shift_reg >>
		(astx_pkg::MAX_CHAR_BITS - char_bits));
	assign win_match = (win == sync_character_reg);
	assign strip_hit = (win_match &&
		control_two_reg[astx_pkg::C2_SYN_STRIP]) ||
		(win == escape_character_reg &&
		control_one_reg[astx_pkg::C1_ESC_STRIP]);
	assign sync_locked = (sync_state_reg == astx_pkg::SY_LOCK);

	// Phase restarts at each mark so the tick lands mid start bit
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			rx_phase_reg <= 5'h00;
		end else if (tick32) begin
			if (!sync_mode && rx_state_reg == astx_pkg::RX_IDLE && rx_line) begin
				rx_phase_reg <= 5'h00;
			end else begin
				rx_phase_reg <= 5'(rx_phase_reg + 1'b1);
			end
		end
	end

	always_ff @(posedge CLK) begin
		push_reg <= 1'b0;
		strip_evt_reg <= 1'b0;
		if (!RESETN || !rx_en) begin
			rx_state_reg <= astx_pkg::RX_IDLE;
			sync_state_reg <= astx_pkg::SY_HUNT;
			rx_count_reg <= 4'h0;
			rx_shift_reg <= 8'h00;
			mark_seen_reg <= 1'b0;
			break_reg <= 1'b0;
			push_data_reg <= 8'h00;
			push_fe_reg <= 1'b0;
		end else if (rx_tick && sync_mode) begin
			rx_shift_reg <= shifted;
			rx_count_reg <= (rx_count_reg == char_bits - 4'h1) ? 4'h0 :
				rx_count_reg + 1'b1;
			case (sync_state_reg)
			astx_pkg::SY_HUNT: begin
				rx_count_reg <= 4'h0;
				if (win_match) begin
					sync_state_reg <= astx_pkg::SY_FIRST;
				end
			end
			astx_pkg::SY_FIRST: begin
				if (rx_count_reg == char_bits - 4'h1) begin
					sync_state_reg <= win_match ? astx_pkg::SY_LOCK :
						astx_pkg::SY_HUNT;
				end
			end
			astx_pkg::SY_LOCK: begin
				if (rx_count_reg == char_bits - 4'h1) begin
					if (strip_hit) begin
						strip_evt_reg <= 1'b1;
					end else begin
						push_reg <= 1'b1;
						push_data_reg <= win;
						push_fe_reg <= 1'b0;
					end
				end
			end
			default: sync_state_reg <= astx_pkg::SY_HUNT;
			endcase
		end else if (rx_tick) begin
			case (rx_state_reg)
			astx_pkg::RX_IDLE: begin
				if (!rx_line && mark_seen_reg) begin
					rx_state_reg <= astx_pkg::RX_DATA;
					rx_count_reg <= 4'h0;
				end else if (rx_line) begin
					mark_seen_reg <= 1'b1;
				end
			end
			astx_pkg::RX_DATA: begin
				if (break_reg && rx_line) begin
					rx_state_reg <= astx_pkg::RX_IDLE;
					break_reg <= 1'b0;
					mark_seen_reg <= 1'b1;
				end else begin
					rx_shift_reg <= shifted;
					if (rx_count_reg == char_bits - 4'h1) begin
						rx_state_reg <= astx_pkg::RX_STOP;
					end
					rx_count_reg <= rx_count_reg + 1'b1;
				end
			end
			astx_pkg::RX_STOP: begin
				push_reg <= 1'b1;
				push_data_reg <= async_char;
				push_fe_reg <= !rx_line;
				rx_count_reg <= 4'h0;
				if (rx_line) begin
					rx_state_reg <= astx_pkg::RX_IDLE;
					break_reg <= 1'b0;
				end else begin
					rx_state_reg <= astx_pkg::RX_DATA;
					break_reg <= (async_char == 8'h00);
				end
			end
			default: rx_state_reg <= astx_pkg::RX_IDLE;
			endcase
		end
	end

	// Receive queue; drain stalls while the holding is unread
	logic fifo_in_ready, fifo_out_valid, hold_load;
	logic [8:0] fifo_out_data;
	assign hold_load = fifo_out_valid && !dr_reg;

	astx_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk(CLK),
		.resetn(RESETN),
		.in_valid(push_reg),
		.in_ready(fifo_in_ready),
		.in_data({push_fe_reg, push_data_reg}),
		.out_valid(fifo_out_valid),
		.out_ready(!dr_reg),
		.out_data(fifo_out_data)
	);

	// Status flags; a setting event wins over a same-cycle read clear
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			receive_holding_reg <= 8'h00;
			dr_reg <= 1'b0;
			framing_reg <= 1'b0;
			overrun_reg <= 1'b0;
			stripped_reg <= 1'b0;
		end else begin
			if (hold_load) begin
				receive_holding_reg <= fifo_out_data[7:0];
				framing_reg <= fifo_out_data[8];
				dr_reg <= 1'b1;
			end else if (rd_end && addr_reg == astx_pkg::RD_RECEIVE_HOLDING) begin
				dr_reg <= 1'b0;
			end
			if (push_reg && !fifo_in_ready) begin
				overrun_reg <= 1'b1;
			end else if (rd_end && addr_reg == astx_pkg::RD_LINE_STATUS) begin
				overrun_reg <= 1'b0;
			end
			if (strip_evt_reg) begin
				stripped_reg <= 1'b1;
			end else if (rd_end && addr_reg == astx_pkg::RD_LINE_STATUS) begin
				stripped_reg <= 1'b0;
			end
		end
	end
endmodule

// File: astx_sva.sv
// Port-level checker for the serial transceiver
`timescale 1ns/1ps
module astx_sva (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// Bus and line
	input wire logic PARALLEL_ACCESS_BUS_OE,
	input wire logic CHIP_SELECT_N,
	input wire logic READ_ENABLE_N,
	input wire logic WRITE_ENABLE_N,
	input wire logic REPLY_N,
	input wire logic TX_DATA,
	input wire logic CLEAR_TO_SEND_N,
	input wire logic REQUEST_TO_SEND_N
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);
	sequence s_bus_quiet;
		(CHIP_SELECT_N && READ_ENABLE_N && WRITE_ENABLE_N) [*7];
	endsequence
	sequence s_bit_hold;
		$stable(TX_DATA) [*6];
	endsequence
	a_reset_quiet: assert property (disable iff (1'b0)
		!RESETN |=> REPLY_N && !PARALLEL_ACCESS_BUS_OE && TX_DATA &&
		REQUEST_TO_SEND_N) else $error("outputs not idle in reset");
	a_cts_mark: assert property (
		CLEAR_TO_SEND_N [*5] |-> TX_DATA) else $error("line not mark");
	a_oe_drop: assert property (
		READ_ENABLE_N [*6] |-> !PARALLEL_ACCESS_BUS_OE)
		else $error("bus driven without read");
	a_reply_end: assert property (
		s_bus_quiet |-> REPLY_N) else $error("reply stuck low");
	a_reply_cause: assert property (
		$fell(REPLY_N) |-> !$past(CHIP_SELECT_N, 2))
		else $error("reply without select");
	a_oe_in_reply: assert property (
		PARALLEL_ACCESS_BUS_OE |-> !REPLY_N) else $error("drive unselected");
	a_reply_hold: assert property (
		!REPLY_N && !CHIP_SELECT_N |=> !REPLY_N) else $error("reply dropped");
	a_bit_hold: assert property (
		$changed(TX_DATA) && !CLEAR_TO_SEND_N |=> s_bit_hold)
		else $error("bit shorter than a bit time");
endmodule
bind astx_transceiver astx_sva u_sva (.CLK(CLK), .RESETN(RESETN),
	.PARALLEL_ACCESS_BUS_OE(PARALLEL_ACCESS_BUS_OE),
	.CHIP_SELECT_N(CHIP_SELECT_N), .READ_ENABLE_N(READ_ENABLE_N),
	.WRITE_ENABLE_N(WRITE_ENABLE_N), .REPLY_N(REPLY_N), .TX_DATA(TX_DATA),
	.CLEAR_TO_SEND_N(CLEAR_TO_SEND_N), .REQUEST_TO_SEND_N(REQUEST_TO_SEND_N));

// File: astx_line_model.sv
// Modem side: free 1X clock, frames sent and captured
`timescale 1ns/1ps
module astx_line_model (
	// Line towards the transceiver
	output logic line_clk,
	output logic rx,
	output logic cts_n,
	input wire logic tx
);
	initial begin
		line_clk = 1'b0;
		rx = 1'b1;
		#7;
		forever #160 line_clk = ~line_clk;
	end
	// Clear to send late, so the forced mark is seen first
	initial begin
		cts_n = 1'b1;
		#2000;
		cts_n = 1'b0;
	end
	task automatic send(input logic [7:0] d, input int n, input logic stp);
		@(negedge line_clk) rx = 1'b0;
		for (int i = 0; i < n; i++) @(negedge line_clk) rx = d[i];
		@(negedge line_clk) rx = stp;
		@(negedge line_clk) rx = 1'b1;
		repeat (2) @(negedge line_clk);
	endtask
	// Sampled at line falls, mid-way between the delayed changes
	task automatic grab(output logic [7:0] d, output logic ok);
		logic s;
		@(negedge tx);
		@(negedge line_clk) s = tx;
		for (int i = 0; i < 8; i++) @(negedge line_clk) d[i] = tx;
		@(negedge line_clk) ok = !s && tx;
	endtask
endmodule

// File: tb.sv
// Self-checking bench: registers, async transmit and receive
`timescale 1ns/1ps
module tb;
	localparam logic [4:0] ID = 5'h0A;
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	logic [7:0] bus_in = 8'h00;
	logic cs_n = 1'b1;
	logic re_n = 1'b1;
	logic we_n = 1'b1;
	logic [7:0] bus_out, q, d;
	logic bus_oe, reply_n, rx, tx, cts_n, rts_n, lclk, ok, replied;
	int error_cnt = 0;
	int n_compared = 0;
	astx_transceiver dut (.CLK(CLK), .RESETN(RESETN),
		.PARALLEL_ACCESS_BUS_IN(bus_in), .PARALLEL_ACCESS_BUS_OUT(bus_out),
		.PARALLEL_ACCESS_BUS_OE(bus_oe), .CHIP_SELECT_N(cs_n),
		.READ_ENABLE_N(re_n), .WRITE_ENABLE_N(we_n), .DEVICE_ID(ID),
		.REPLY_N(reply_n), .RX_DATA(rx), .TX_DATA(tx),
		.CLEAR_TO_SEND_N(cts_n), .REQUEST_TO_SEND_N(rts_n),
		.LINE_CLK_1X(lclk), .RATE_CLK_32X(4'h0));
	astx_line_model m (.line_clk(lclk), .rx(rx), .cts_n(cts_n), .tx(tx));
	initial forever #20 CLK = ~CLK;
	task automatic chk(input string s, input logic [7:0] e,
		input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic end_of_test;
		if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic acc(input logic [4:0] id, input logic [2:0] a,
		input logic rd, input logic [7:0] wd);
		@(posedge CLK) bus_in <= {id, a};
		@(posedge CLK) cs_n <= 1'b0;
		for (int i = 0; i < 12 && reply_n !== 1'b0; i++) @(posedge CLK);
		replied = (reply_n === 1'b0);
		if (replied) begin
			bus_in <= wd;
			repeat (4) @(posedge CLK);
			if (rd) re_n <= 1'b0;
			else we_n <= 1'b0;
			for (int i = 0; i < 12 && bus_oe !== rd; i++) @(posedge CLK);
			repeat (4) @(posedge CLK);
			q = bus_out;
			re_n <= 1'b1;
			we_n <= 1'b1;
			repeat (3) @(posedge CLK);
		end
		cs_n <= 1'b1;
		for (int i = 0; i < 12 && reply_n !== 1'b1; i++) @(posedge CLK);
		repeat (4) @(posedge CLK);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e, string s);
		acc(ID, a, 1'b1, 8'h00);
		chk(s, e, q);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		acc(ID, a, 1'b0, v);
	endtask
	initial begin
		repeat (6) @(posedge CLK);
		RESETN <= 1'b1;
		repeat (3) @(posedge CLK);
		rd(astx_pkg::RD_CONTROL_ONE, astx_pkg::CONTROL_RESET, "ctl1");
		rd(astx_pkg::RD_CONTROL_TWO, astx_pkg::CONTROL_RESET, "ctl2");
		// Eight bits, two stop bits
		wr(astx_pkg::WR_CONTROL_TWO, 8'h13);
		rd(astx_pkg::RD_CONTROL_TWO, 8'h13, "ctl2");
		acc(5'h0B, astx_pkg::WR_CONTROL_ONE, 1'b0, 8'hFF);
		chk("foreign reply", 8'h00, {7'h00, replied});
		wr(astx_pkg::WR_CONTROL_ONE, 8'h03);
		rd(astx_pkg::RD_CONTROL_ONE, 8'h03, "ctl1");
		chk("rts", 8'h00, {7'h00, rts_n});
		fork
			begin
				m.grab(d, ok);
				chk("tx char", 8'hA5, d);
				chk("tx frame", 8'h01, {7'h00, ok});
				m.grab(d, ok);
				chk("tx next", 8'h3C, d);
				chk("tx frame", 8'h01, {7'h00, ok});
			end
			begin
				wr(astx_pkg::WR_TRANSMIT_HOLDING, 8'hA5);
				wr(astx_pkg::WR_TRANSMIT_HOLDING, 8'h3C);
			end
		join
		// Five bits, one stop bit
		wr(astx_pkg::WR_CONTROL_TWO, 8'h00);
		m.send(8'h35, 5, 1'b1);
		repeat (20) @(posedge CLK);
		rd(astx_pkg::RD_RECEIVE_HOLDING, 8'h15, "rx char");
		rd(astx_pkg::RD_LINE_STATUS, 8'h50, "status");
		m.send(8'h0A, 5, 1'b0);
		repeat (20) @(posedge CLK);
		rd(astx_pkg::RD_LINE_STATUS, 8'h55, "status");
		rd(astx_pkg::RD_RECEIVE_HOLDING, 8'h0A, "rx char");
		// Mark after a zero stop is taken as an all-ones character
		rd(astx_pkg::RD_RECEIVE_HOLDING, 8'h1F, "rx char");
		m.send(8'h11, 5, 1'b1);
		repeat (20) @(posedge CLK);
		rd(astx_pkg::RD_RECEIVE_HOLDING, 8'h11, "rx char");
		// Sync mode on the internal loop: fill, hunt, lock, strip
		wr(astx_pkg::WR_CONTROL_TWO, 8'h0B);
		wr(astx_pkg::WR_SYNC_ESCAPE, 8'h16);
		wr(astx_pkg::WR_CONTROL_ONE, 8'h0F);
		repeat (250) @(posedge CLK);
		rd(astx_pkg::RD_LINE_STATUS, 8'h78, "sync");
		end_of_test();
	end
	initial begin
		#300000;
		error_cnt++;
		end_of_test();
	end
endmodule
